// ---- include/clock_mode_cfg.svh ----
// Functional notes
// - Latch three strap pins while hard reset held
// - Config select extends code with four data bits
// - Basic codes 000-111 decode, 33 MHz input
// - Extended 0001_000-0001_100: comm two, core 4-8
// - Only power-on reset permits a new configuration
// - Bus outputs on rising edge; memory on ticks
// - Four ticks per cycle; T1 rise, T3 fall
// - T2/T4 placement follows the PLL ratio
// - Extended codes from 0100_001 are reserved
`ifndef CLOCK_MODE_CFG_SVH
`define CLOCK_MODE_CFG_SVH
`define STRAP_W 3
`define HIGH_W 4
`define CODE_W 7
`define FACTOR_W 5
`define EXT_RESERVED_FIRST 7'h21
`define TICK_PHASE_W 4
`define FACTOR_RESET 5'h00
`define CODE_RESET 7'h00
`define RATIO_RESET 2'h3
`define TICK_RESET 4'h1
`endif

// ---- include/clock_mode_pkg.sv ----
`default_nettype none
package clock_mode_pkg;
  // Factors are held in half units: value 5 means 2.5
  typedef logic [4:0] factor_type;
  typedef enum logic [2:0] {
    ratio_int,
    ratio_2p5,
    ratio_3p5,
    ratio_none
  } ratio_type;
endpackage
`default_nettype wire

// ---- hdl/clock_mode_decode.sv ----
`include "clock_mode_cfg.svh"
`default_nettype none
module clock_mode_decode
  import clock_mode_pkg::*;
(
  input wire logic [`CODE_W-1:0] code,
  input wire logic extended,
  output factor_type comm_factor,
  output factor_type core_factor,
  output logic valid
);
  logic [`STRAP_W-1:0] low;
  assign low = code[`STRAP_W-1:0];
  always_comb begin
    comm_factor = `FACTOR_RESET;
    core_factor = `FACTOR_RESET;
    valid = 1'b0;
    if (!extended) begin
      valid = 1'b1;
      unique case (low)
        3'h0: begin comm_factor = 5'h06; core_factor = 5'h08; end
        3'h1: begin comm_factor = 5'h06; core_factor = 5'h0A; end
        3'h2: begin comm_factor = 5'h08; core_factor = 5'h08; end
        3'h3: begin comm_factor = 5'h08; core_factor = 5'h0A; end
        3'h4: begin comm_factor = 5'h04; core_factor = 5'h05; end
        3'h5: begin comm_factor = 5'h04; core_factor = 5'h06; end
        3'h6: begin comm_factor = 5'h05; core_factor = 5'h05; end
        3'h7: begin comm_factor = 5'h05; core_factor = 5'h06; end
      endcase
    end else if (code >= 7'h08 && code <= 7'h0C) begin
      valid = 1'b1;
      comm_factor = 5'h04;
      core_factor = 5'(({2'h0, code[2:0]} + 5'h04) << 1);
    end else if (code >= `EXT_RESERVED_FIRST) begin
      valid = 1'b0;
    end
  end
endmodule // clock_mode_decode
`default_nettype wire

// ---- hdl/reset_clock_mode_select.sv ----
`include "clock_mode_cfg.svh"
`default_nettype none
module reset_clock_mode_select
  import clock_mode_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic power_on_reset,
  input wire logic hard_reset_in,
  input wire logic reset_config_select,
  input wire logic [`STRAP_W-1:0] clock_strap_pins,
  input wire logic [`HIGH_W-1:0] clock_strap_high_bits,
  output factor_type comm_factor_q,
  output factor_type core_factor_q,
  output logic config_valid_q,
  output logic config_locked_q,
  output logic [1:0] ratio_q,
  output logic [`TICK_PHASE_W-1:0] tick_phase_q
);
  typedef enum logic [1:0] {
    st_wait_por,
    st_sampling,
    st_locked
  } state_type;

  // Sequencer, captured code and next values
  state_type state_q;
  state_type state_d;
  logic [`CODE_W-1:0] code_q;
  logic [`CODE_W-1:0] code_d;
  logic [`CODE_W-1:0] code_src;
  logic ext_q;
  logic ext_d;
  logic arm;
  logic capture;
  logic commit;
  factor_type comm_factor_d;
  factor_type core_factor_d;
  factor_type dec_comm;
  factor_type dec_core;
  logic dec_valid;
  logic config_valid_d;
  logic config_locked_d;
  logic [1:0] ratio_d;
  logic [`TICK_PHASE_W-1:0] tick_phase_d;

  // Table lookup of the captured code
  clock_mode_decode u_decode (
    .code(code_q),
    .extended(ext_q),
    .comm_factor(dec_comm),
    .core_factor(dec_core),
    .valid(dec_valid)
  );

  // Sequencer: power-on reset arms, hard reset captures, release commits
  always_comb begin
    state_d = state_q;
    arm = 1'b0;
    capture = 1'b0;
    commit = 1'b0;
    unique case (state_q)
      st_wait_por: begin
        if (power_on_reset) begin
          state_d = st_sampling;
          arm = 1'b1;
        end
      end
      st_sampling: begin
        if (hard_reset_in) begin
          capture = 1'b1;
        end else begin
          state_d = st_locked;
          commit = 1'b1;
        end
      end
      st_locked: begin
        // Hard reset alone leaves the selection in place
        if (power_on_reset) begin
          state_d = st_sampling;
          arm = 1'b1;
        end
      end
      default: begin
        state_d = st_wait_por;
      end
    endcase
  end

  // Sequencer state; a low enable freezes every group below as well
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= st_wait_por;
    end else if (clock_enable) begin
      state_q <= state_d;
    end
  end

  // Straps in the low bits, high bits only when extended mode is selected
  for (genvar b = 0; b < `CODE_W; b++) begin : g_code
    if (b < `STRAP_W) begin : g_strap
      assign code_src[b] = clock_strap_pins[b];
    end else begin : g_high
      assign code_src[b] = reset_config_select & clock_strap_high_bits[b-`STRAP_W];
    end
  end

  always_comb begin
    code_d = code_q;
    ext_d = ext_q;
    if (capture) begin
      code_d = code_src;
      ext_d = reset_config_select;
    end
  end

  // Captured code registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      code_q <= `CODE_RESET;
      ext_q <= 1'b0;
    end else if (clock_enable) begin
      code_q <= code_d;
      ext_q <= ext_d;
    end
  end

  // Factors change only when a new selection commits
  always_comb begin
    comm_factor_d = comm_factor_q;
    core_factor_d = core_factor_q;
    if (commit) begin
      comm_factor_d = dec_comm;
      core_factor_d = dec_core;
    end
  end

  // Factor registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      comm_factor_q <= `FACTOR_RESET;
      core_factor_q <= `FACTOR_RESET;
    end else if (clock_enable) begin
      comm_factor_q <= comm_factor_d;
      core_factor_q <= core_factor_d;
    end
  end

  // Status: locked drops when armed and rises on commit
  always_comb begin
    config_valid_d = config_valid_q;
    config_locked_d = config_locked_q;
    if (arm) begin
      config_locked_d = 1'b0;
    end else if (commit) begin
      config_valid_d = dec_valid;
      config_locked_d = 1'b1;
    end
  end

  // Status registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      config_valid_q <= 1'b0;
      config_locked_q <= 1'b0;
    end else if (clock_enable) begin
      config_valid_q <= config_valid_d;
      config_locked_q <= config_locked_d;
    end
  end

  // Tick spacing class from the core factor in half units
  always_comb begin
    unique case (core_factor_d)
      5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C: begin
        // Integer ratios 1:2 to 1:6
        ratio_d = 2'(ratio_int);
      end
      5'h05: begin
        ratio_d = 2'(ratio_2p5);
      end
      5'h07: begin
        ratio_d = 2'(ratio_3p5);
      end
      default: begin
        ratio_d = 2'(ratio_none);
      end
    endcase
  end

  // Ratio register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ratio_q <= `RATIO_RESET;
    end else if (clock_enable) begin
      ratio_q <= ratio_d;
    end
  end

  // One-hot tick marker: each bit takes its lower neighbour, T4 wraps to T1
  for (genvar i = 0; i < `TICK_PHASE_W; i++) begin : g_tick
    if (i == 0) begin : g_wrap
      assign tick_phase_d[i] = tick_phase_q[`TICK_PHASE_W-1];
    end else begin : g_shift
      assign tick_phase_d[i] = tick_phase_q[i-1];
    end
  end

  // Marker advances on the rising edge that also launches bus outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_phase_q <= `TICK_RESET;
    end else if (clock_enable) begin
      tick_phase_q <= tick_phase_d;
    end
  end
endmodule // reset_clock_mode_select
`default_nettype wire

// ---- bench/rcms_monitor.sv ----
`default_nettype none
module rcms_monitor
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic power_on_reset,
  input wire logic [4:0] core_factor_q,
  input wire logic config_valid_q,
  input wire logic config_locked_q,
  input wire logic [3:0] tick_phase_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_hold; config_locked_q |=> $stable(core_factor_q); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_keep; config_locked_q && !power_on_reset |=> config_locked_q; endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_arm; power_on_reset && clock_enable |=> !config_locked_q; endproperty
  a_arm: assert property (p_arm) else $error("arm");
  property p_wait; power_on_reset |=> $stable(core_factor_q); endproperty
  a_wait: assert property (p_wait) else $error("wait");
  property p_bad; !config_valid_q |-> core_factor_q == 5'h00; endproperty
  a_bad: assert property (p_bad) else $error("bad");
  property p_one; $onehot(tick_phase_q); endproperty
  a_one: assert property (p_one) else $error("one");
  property p_turn; clock_enable |=> tick_phase_q != $past(tick_phase_q); endproperty
  a_turn: assert property (p_turn) else $error("turn");
  property p_stop; !clock_enable |=> $stable(tick_phase_q); endproperty
  a_stop: assert property (p_stop) else $error("stop");
endmodule // rcms_monitor
bind reset_clock_mode_select rcms_monitor mon (.*);
`default_nettype wire

// ---- bench/strap_src.sv ----
`default_nettype none
module strap_src
(
  input wire logic clock,
  input wire logic go,
  input wire logic [6:0] code,
  output logic hard_reset_in,
  output logic [2:0] clock_strap_pins,
  output logic [3:0] clock_strap_high_bits
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clock) hard_reset_in <= go;
  // Straps pulled high outside hard reset
  assign {clock_strap_high_bits, clock_strap_pins} = hard_reset_in ? code : 7'h7F;
endmodule // strap_src
`default_nettype wire

// ---- bench/testbench.sv ----
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR %0t %h %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'h0, rst = 1'h1, clock_enable = 1'h1, power_on_reset = 1'h0, go = 1'h0;
  logic reset_config_select = 1'h0, hard_reset_in, config_valid_q, config_locked_q;
  logic [6:0] code = 7'h00;
  logic [2:0] clock_strap_pins;
  logic [3:0] clock_strap_high_bits, tick_phase_q;
  logic [4:0] comm_factor_q, core_factor_q;
  logic [1:0] ratio_q;
  int mismatches = 0, comparisons = 0, cycles = 0;
  reset_clock_mode_select DUT (.*);
  strap_src partner (.*);
  always #5 clock = ~clock;
  always @(posedge clock) if (++cycles > 999) begin
    mismatches++;
    tally_and_finish();
  end
  task automatic tally_and_finish();
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic pick(input logic [6:0] c, input logic s, p, input logic [4:0] ec, ek);
    @(posedge clock) power_on_reset <= p;
    go <= 1'h1;
    code <= c;
    reset_config_select <= s;
    @(posedge clock) power_on_reset <= 1'h0;
    repeat (2) @(posedge clock);
    go <= 1'h0;
    repeat (3) @(posedge clock);
    #1;
    `CHK(comm_factor_q, ec)
    `CHK(core_factor_q, ek)
    `CHK(config_valid_q, ek != 5'h00)
    `CHK(config_locked_q, 1'h1)
    `CHK(ratio_q, exp_ratio(ek))
  endtask
  function automatic logic [1:0] exp_ratio(input logic [4:0] k);
    if (k == 5'h05) return 2'h1;
    if (k == 5'h07) return 2'h2;
    if (k >= 5'h04 && k <= 5'h0C && !k[0]) return 2'h0;
    return 2'h3;
  endfunction
  task automatic freeze();
    logic [3:0] t;
    @(posedge clock) clock_enable <= 1'h0;
    @(posedge clock) power_on_reset <= 1'h1;
    #1 t = tick_phase_q;
    @(posedge clock) power_on_reset <= 1'h0;
    repeat (2) @(posedge clock);
    #1;
    `CHK(tick_phase_q, t)
    `CHK(config_locked_q, 1'h1)
    @(posedge clock) clock_enable <= 1'h1;
    @(posedge clock);
    #1;
    `CHK(tick_phase_q, {t[2:0], t[3]})
    `CHK(config_locked_q, 1'h1)
  endtask
  task automatic basic_modes();
    for (int i = 0; i < 8; i++) pick({4'hA, i[2:0]}, 1'h0, 1'h1,
      i < 4 ? 5'h06 + {i[1], 1'h0} : 5'h04 + i[1], i < 4 ? 5'h08 + {i[0], 1'h0} : 5'h05 + i[0]);
  endtask
  task automatic extended_modes();
    pick(7'h21, 1'h1, 1'h1, 5'h00, 5'h00);
    for (int i = 0; i < 5; i++) pick(7'h08 + i[2:0], 1'h1, 1'h1, 5'h04,
      5'h08 + {i[2:0], 1'h0});
    pick(7'h08, 1'h1, 1'h0, 5'h04, 5'h10);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    basic_modes();
    extended_modes();
    freeze();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
